// ### verif/sfsw_chk.sv
// port assertions for the status-write and id-read block
`default_nettype none
module sfsw_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic wp_b,
  input wire logic so_oe_b,
  input wire logic wel_set,
  input wire logic wel_clr,
  input wire logic write_enable_latch,
  input wire logic protection_lock,
  input wire logic array_protect,
  input wire logic reset_command_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] bits;
  assign bits = {protection_lock, array_protect, reset_command_enable};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // latch and status bits
  a_wel_set: assert property (wel_set |=> write_enable_latch) else $error("latch not set");
  a_wel_clr: assert property (wel_clr && !wel_set |=> !write_enable_latch) else $error("latch not cleared");
  a_wel_source: assert property ($rose(write_enable_latch) |-> $past(wel_set)) else $error("latch rose alone");
  a_bits_need_wel: assert property ($changed(bits) |-> $past(write_enable_latch)) else $error("write without latch");
  // the latch drops one cycle after the status bits take their new value
  a_commit_clears: assert property ($changed(bits) |=> !write_enable_latch || $past(wel_set))
    else $error("latch kept after write");
  a_hold_in_frame: assert property ((!cs_b)[*8] |=> $stable(bits)) else $error("bits moved while selected");
  a_wp_lock: assert property ((protection_lock && !wp_b)[*8] |=> $stable(bits[2:1]))
    else $error("locked bits moved under write protect");
  // ==========================================
  // serial output
  a_idle_float: assert property (cs_b[*8] |-> so_oe_b) else $error("output driven while deselected");
endmodule
bind sfsw_core sfsw_chk sfsw_chk_i (.clk, .rst_b, .cs_b, .wp_b, .so_oe_b, .wel_set, .wel_clr,
  .write_enable_latch, .protection_lock, .array_protect, .reset_command_enable);
`default_nettype wire

// ### verif/sfsw_host.sv
// host spi master model: chip select, serial clock and data, mode 0
`default_nettype none
module sfsw_host #(
  parameter int HALF = 20
) (
  input  wire logic clk,
  output var  logic cs_b,
  output var  logic sck,
  output var  logic si,
  input  wire logic so_o,
  input  wire logic so_oe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // ==========================================
  // one framed transfer, sck still outside it
  task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx, output logic [47:0] oe);
    rx = '0;
    oe = '1;
    cs_b <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      si <= tx[47-i];
      repeat (HALF) @(posedge clk);
      // a released line floats up to the pull-up level
      rx[47-i] = so_oe_b ? 1'b1 : so_o;
      oe[47-i] = so_oe_b;
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_b <= 1'b1;
    // stale data must never look like a valid last bit
    si <= ~si;
    repeat (4 * HALF) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### verif/tb_spi_flash_status_write_and_id_read.sv
// self-checking bench for the status-write and id-read block
`default_nettype none
module tb_spi_flash_status_write_and_id_read;
  timeunit 1ns;
  timeprecision 1ps;
  // id values are arbitrary
  localparam logic [7:0] MANUF = 8'h3c;
  localparam logic [2:0] FAM = 3'h6;
  localparam logic [4:0] DENS = 5'h11;
  localparam logic [2:0] SUBC = 3'h5;
  localparam logic [4:0] VER = 5'h09;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic wel_set = 1'b0;
  logic wel_clr = 1'b0;
  logic cs_b, sck, si, so_o, so_oe_b;
  logic write_enable_latch, protection_lock, array_protect, reset_command_enable;
  logic [7:0] protection_status_byte, reset_enable_status_byte;
  logic [47:0] rx, oe;
  logic [3:0] st;
  logic [7:0] op, d;
  int n;
  int n_fail = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  sfsw_host sfsw_host_i (.clk, .cs_b, .sck, .si, .so_o, .so_oe_b);
  sfsw_core #(.MANUF_ID(MANUF), .FAMILY(FAM), .DENSITY(DENS), .SUB_CODE(SUBC), .PROD_VER(VER)) sfsw_core_i (
    .clk, .rst_b, .cs_b, .sck, .si, .wp_b, .so_o, .so_oe_b, .wel_set, .wel_clr, .write_enable_latch,
    .protection_lock, .array_protect, .reset_command_enable, .protection_status_byte, .reset_enable_status_byte);
  // ==========================================
  // checking
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // state is {lock, array protect, reset enable, latch}
  function automatic logic [3:0] predict(logic [3:0] s, logic [7:0] o, logic [7:0] b, logic whole, logic wpn);
    if (!s[0] || (o != 8'h01 && o != 8'h31)) return s;
    s[0] = 1'b0;
    if (!whole) return s;
    if (o == 8'h31) s[1] = b[4];
    else if (wpn || !s[3] || b[7]) begin
      if (wpn || !s[3]) s[2] = b[2];
      s[3] = b[7];
    end
    return s;
  endfunction
  task automatic check_state;
    check("bits", {protection_lock, array_protect, reset_command_enable, write_enable_latch}, st);
    check("prot byte", protection_status_byte, {st[3], 4'h0, st[2], st[0], 1'b0});
    check("reset_command_enable byte", reset_enable_status_byte, {3'h0, st[1], 4'h0});
  endtask
  // ==========================================
  // tests
  initial begin
    void'($urandom(59));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    st = 4'h0;
    check_state;
    check("so idle", so_oe_b, 1'b1);
    for (int it = 0; it < 30; it++) begin
      d = $urandom;
      n = $urandom_range(5);
      // unknown opcode leaves everything, latch included, as it was
      op = (n < 2) ? 8'h31 : (n < 4) ? 8'h01 : 8'h5b;
      n = $urandom_range(3);
      wp_b <= $urandom_range(1);
      // first two writes go in with the latch clear
      wel_set <= it > 1 && $urandom_range(3) != 0;
      wel_clr <= $urandom_range(1);
      @(posedge clk);
      st[0] = wel_set | (st[0] & ~wel_clr);
      wel_set <= 1'b0;
      wel_clr <= 1'b0;
      repeat (8) @(posedge clk);
      n = (n == 0) ? 16 : (n == 1) ? 24 : (n == 2) ? 8 + $urandom_range(7) : 17 + $urandom_range(6);
      sfsw_host_i.xfer({op, d, ~d, 24'h0}, n, rx, oe);
      st = predict(st, op, d, n == 16 || n == 24, wp_b);
      check_state;
      $display("write test %0d done", it);
    end
    for (int k = 0; k < 2; k++) begin
      sfsw_host_i.xfer({8'h9f, 40'h0}, k ? 20 : 48, rx, oe);
      if (k == 0) begin
        check("id bytes", rx[39:8], {MANUF, FAM, DENS, SUBC, VER, 8'h00});
        check("id drive", oe, {8'hff, 32'h0, 8'hff});
      end
      check("so released", so_oe_b, 1'b1);
      $display("id test %0d done", k);
    end
    complete_run;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    complete_run;
  end
endmodule
`default_nettype wire

// ### verilog/sfsw_core.v
// spi command handler for protection, reset-enable writes and id read
`include "sfsw_regs.vh"
`default_nettype none
// Operation
// - protection write is opcode 01h plus one byte, needs write enable latch set
// - data bit 7 gives new lock, bit 2 gives array protect; rest ignored
// - bytes after the single data byte are ignored
// - at deselect after valid write, update lock and protect, clear latch
// - protection change depends on new lock, prior lock and write-protect pin
// - short or unaligned protection write aborts, clears latch, keeps bits
// - with write-protect asserted lock may only be set; clearing is ignored
// - reset-enable write is opcode 31h plus one byte after write enable
// - data bit 4 is the new reset-command enable value
// - at deselect after valid write, update reset enable, clear latch
// - short or unaligned reset-enable write aborts, keeps bit, clears latch
// - id read opcode 9Fh, then id bytes driven on serial output
// - output manufacturer, two device bytes, then zero extension length
// - after length byte serial output floats, no more data
// - deselect ends id read and floats serial output, even mid-byte
// - id byte one family and density, byte two sub code and version
// - with latch clear, both status writes are refused; latch clear at reset
// - lock set with write-protect asserted freezes array protect
// - reset enable powers up zero
module sfsw_core #(
  parameter [7:0] MANUF_ID   = 8'h5a, // arbitrary value
  parameter [2:0] FAMILY     = 3'h5,  // arbitrary value
  parameter [4:0] DENSITY    = 5'h0a, // arbitrary value
  parameter [2:0] SUB_CODE   = 3'h2,  // arbitrary value
  parameter [4:0] PROD_VER   = 5'h03  // arbitrary value
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       cs_b,
  input  wire       sck,
  input  wire       si,
  input  wire       wp_b,
  output wire       so_o,
  output wire       so_oe_b,
  input  wire       wel_set,
  input  wire       wel_clr,
  output reg        write_enable_latch,
  output reg        protection_lock,
  output reg        array_protect,
  output reg        reset_command_enable,
  output wire [7:0] protection_status_byte,
  output wire [7:0] reset_enable_status_byte
);
  // ==========================================================================
  // pin synchronisers
  wire cs_b_s;
  wire sck_s;
  wire si_s;
  wire wp_b_s;

  sfsw_sync #(.INIT(1'b1)) u_sync_cs (.clk(clk), .rst_b(rst_b), .pin(cs_b), .level(cs_b_s));
  sfsw_sync #(.INIT(1'b0)) u_sync_sck (.clk(clk), .rst_b(rst_b), .pin(sck), .level(sck_s));
  sfsw_sync #(.INIT(1'b0)) u_sync_si (.clk(clk), .rst_b(rst_b), .pin(si), .level(si_s));
  sfsw_sync #(.INIT(1'b1)) u_sync_wp (.clk(clk), .rst_b(rst_b), .pin(wp_b), .level(wp_b_s));

  // ==========================================================================
  // edge detection
  reg  sck_d_r;
  reg  cs_d_r;
  wire sel      = ~cs_b_s;
  wire rise     = sel & sck_s & ~sck_d_r;
  wire fall     = sel & ~sck_s & sck_d_r;
  wire deselect = cs_b_s & ~cs_d_r;
  wire select   = ~cs_b_s & cs_d_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r  <= cs_b_s;
    end
  end

  // ==========================================================================
  // shifter
  wire [7:0] rx_byte;
  wire       rx_done;
  wire [2:0] bit_cnt;
  wire       dout;
  reg        load_r;
  reg  [7:0] load_byte_r;

  sfsw_shift u_shift (
    .clk      (clk),
    .rst_b    (rst_b),
    .clr      (select),
    .rise     (rise),
    .fall     (fall),
    .din      (si_s),
    .load     (load_r),
    .load_byte(load_byte_r),
    .rx_byte  (rx_byte),
    .rx_done  (rx_done),
    .bit_cnt  (bit_cnt),
    .dout     (dout)
  );

  // ==========================================================================
  // command state machine
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_OPC   = 3'd1;
  localparam [2:0] ST_PDATA = 3'd2;
  localparam [2:0] ST_RDATA = 3'd3;
  localparam [2:0] ST_ID    = 3'd4;
  localparam [2:0] ST_SKIP  = 3'd5;

  reg [2:0] state_r;
  reg       got_data_r;
  reg [7:0] data_r;
  reg       is_prot_r;
  reg [2:0] id_idx_r;
  reg       drive_r;

  wire [7:0] id_dev1 = {FAMILY, DENSITY};
  wire [7:0] id_dev2 = {SUB_CODE, PROD_VER};

  reg [7:0] id_byte;
  always @* begin
    case (id_idx_r)
      3'd0:    id_byte = MANUF_ID;
      3'd1:    id_byte = id_dev1;
      3'd2:    id_byte = id_dev2;
      default: id_byte = `SFSW_EXT_LEN;
    endcase
  end

  wire       aligned  = (bit_cnt == 3'd0);
  wire       wp_on    = ~wp_b_s;
  wire       new_lock = data_r[`SFSW_PROT_LOCK_BIT];
  // clearing the lock under write-protect kills the whole write
  wire       lock_veto = wp_on & protection_lock & ~new_lock;
  wire       ap_frozen = wp_on & protection_lock;
  wire       commit   = got_data_r & aligned;
  reg        wel_drop;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= ST_IDLE;
      got_data_r  <= 1'b0;
      data_r      <= 8'h00;
      is_prot_r   <= 1'b0;
      id_idx_r    <= 3'd0;
      drive_r     <= 1'b0;
      load_r      <= 1'b0;
      load_byte_r <= 8'h00;
      protection_lock      <= `SFSW_RST_LOCK;
      array_protect        <= `SFSW_RST_ARRAY;
      reset_command_enable <= `SFSW_RST_RSTEN;
      wel_drop    <= 1'b0;
    end else begin
      load_r   <= 1'b0;
      wel_drop <= 1'b0;
      if (deselect) begin
        drive_r <= 1'b0;
        if (state_r == ST_PDATA || state_r == ST_RDATA) begin
          wel_drop <= 1'b1;
          if (commit && is_prot_r && !lock_veto) begin
            protection_lock <= new_lock;
            if (!ap_frozen) begin
              array_protect <= data_r[`SFSW_PROT_ARRAY_BIT];
            end
          end
          if (commit && !is_prot_r) begin
            reset_command_enable <= data_r[`SFSW_RSTEN_BIT];
          end
        end
        state_r <= ST_IDLE;
      end else if (select) begin
        state_r    <= ST_OPC;
        got_data_r <= 1'b0;
      end else if (rx_done) begin
        case (state_r)
          ST_OPC: begin
            if (rx_byte == `SFSW_OP_WRITE_PROT && write_enable_latch) begin
              state_r   <= ST_PDATA;
              is_prot_r <= 1'b1;
            end else if (rx_byte == `SFSW_OP_WRITE_RSTEN && write_enable_latch) begin
              state_r   <= ST_RDATA;
              is_prot_r <= 1'b0;
            end else if (rx_byte == `SFSW_OP_READ_ID) begin
              state_r     <= ST_ID;
              id_idx_r    <= 3'd1;
              load_r      <= 1'b1;
              load_byte_r <= MANUF_ID;
              drive_r     <= 1'b1;
            end else begin
              state_r <= ST_SKIP;
            end
          end
          ST_PDATA, ST_RDATA: begin
            if (!got_data_r) begin
              data_r     <= rx_byte;
              got_data_r <= 1'b1;
            end
          end
          ST_ID: begin
            if (id_idx_r == `SFSW_ID_BYTES) begin
              drive_r <= 1'b0;
              state_r <= ST_SKIP;
            end else begin
              load_r      <= 1'b1;
              load_byte_r <= id_byte;
              id_idx_r    <= id_idx_r + 3'd1;
            end
          end
          default: state_r <= state_r;
        endcase
      end
    end
  end

  // ==========================================================================
  // write enable latch, shared with the rest of the device
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_enable_latch <= `SFSW_RST_WEL;
    end else if (wel_set) begin
      write_enable_latch <= 1'b1;
    end else if (wel_drop || wel_clr) begin
      write_enable_latch <= 1'b0;
    end
  end

  // ==========================================================================
  // status views and serial output
  assign protection_status_byte   = {protection_lock, 4'h0, array_protect, write_enable_latch, 1'b0};
  assign reset_enable_status_byte = {3'h0, reset_command_enable, 4'h0};
  assign so_o    = dout;
  assign so_oe_b = ~(drive_r & sel);
endmodule
`default_nettype wire

// ### verilog/sfsw_regs.vh
// constants of the serial flash status-write and identification block
`ifndef SFSW_REGS_VH
`define SFSW_REGS_VH
// ==========================================================================
// opcodes
`define SFSW_OP_WRITE_PROT   8'h01
`define SFSW_OP_WRITE_RSTEN  8'h31
`define SFSW_OP_READ_ID      8'h9f
`define SFSW_OP_WRITE_ENABLE 8'h06
`define SFSW_OP_WRITE_DIS    8'h04
// ==========================================================================
// field positions
`define SFSW_PROT_LOCK_BIT   3'd7
`define SFSW_PROT_ARRAY_BIT  3'd2
`define SFSW_RSTEN_BIT       3'd4
`define SFSW_ID_FAMILY_MSB   7
`define SFSW_ID_FAMILY_LSB   5
`define SFSW_ID_DENS_MSB     4
`define SFSW_ID_DENS_LSB     0
// ==========================================================================
// reset values and counts
`define SFSW_RST_LOCK        1'b0
`define SFSW_RST_ARRAY       1'b0
`define SFSW_RST_RSTEN       1'b0
`define SFSW_RST_WEL         1'b0
`define SFSW_ID_BYTES        3'd4
`define SFSW_EXT_LEN         8'h00
`endif

// ### verilog/sfsw_shift.v
// serial byte shifter: msb-first input assembly and output serialiser
`default_nettype none
module sfsw_shift (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       clr,
  input  wire       rise,
  input  wire       fall,
  input  wire       din,
  input  wire       load,
  input  wire [7:0] load_byte,
  output reg  [7:0] rx_byte,
  output reg        rx_done,
  output reg  [2:0] bit_cnt,
  output reg        dout
);
  reg [7:0] tx_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_byte <= 8'h00;
      rx_done <= 1'b0;
      bit_cnt <= 3'd0;
      tx_r    <= 8'h00;
      dout    <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (clr) begin
        bit_cnt <= 3'd0;
      end else if (rise) begin
        rx_byte <= {rx_byte[6:0], din};
        bit_cnt <= bit_cnt + 3'd1;
        if (bit_cnt == 3'd7) begin
          rx_done <= 1'b1;
        end
      end
      // output changes on the falling edge so the host samples it rising
      if (load) begin
        tx_r <= load_byte;
        dout <= load_byte[7];
      end else if (fall && bit_cnt != 3'd0) begin
        dout <= tx_r[3'd7 - bit_cnt];
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/sfsw_sync.v
// three-stage synchroniser with agreement filter for one pin
`default_nettype none
module sfsw_sync #(
  parameter INIT = 1'b0
) (
  input  wire clk,
  input  wire rst_b,
  input  wire pin,
  output reg  level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // level only moves once stages two and three agree
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // start at the pin's idle level so no false edge follows reset
      s1_r  <= INIT;
      s2_r  <= INIT;
      s3_r  <= INIT;
      level <= INIT;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire
